// *** dv/dsmg_top_tb.sv ***
// Purpose: Self-checking bench for the wake flags, scratch words and clock gates
// Assumes: APB slave answers with pready; event inputs are sampled each rising edge
// Notes: Expected values come from fixed tables, never from the design outputs

module dsmg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [15:0] pa = 16'h0000;
  logic [31:0] pwd = 32'h0000_0000, cfg3 = 32'h0000_0000, prd, rd;
  logic pready, perr, e, dsel, ret, lock;
  logic unl = 1'b1, dsa = 1'b0, bat = 1'b0, por = 1'b0, mce = 1'b0;
  // Event order: change notice, fault, watchdog, alarm, master clear pin
  logic [4:0] evt = 5'h00;
  logic [31:0] g [6];
  int n_errors = 0, n_tests = 0;
  localparam logic [31:0] GM [6] = '{32'h0010_1101, 32'h0000_0007, 32'h001F_001F,
    32'h0000_001F, 32'h0103_0303, 32'h0001_0003};
  localparam int FB [5] = '{8, 7, 4, 3, 2};

  dsmg_top uut (.mclk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(pready), .pslverr_out(perr), .system_unlocked_in(unl),
    .configuration_word_three_in(cfg3), .deep_sleep_active_in(dsa),
    .battery_mode_in(bat), .supply_por_in(por), .change_notice_event_in(evt[0]),
    .sleep_fault_event_in(evt[1]), .sleep_watchdog_expiry_in(evt[2]),
    .calendar_alarm_in(evt[3]), .master_clear_enable_in(mce),
    .master_clear_pin_in(evt[4]), .deep_sleep_select_out(dsel),
    .scratch_retention_enable_out(ret), .gate_write_lock_out(lock),
    .module_gate_analog_out(g[0]), .module_gate_comparators_out(g[1]),
    .module_gate_capture_compare_out(g[2]), .module_gate_timers_out(g[3]),
    .module_gate_serial_out(g[4]), .module_gate_misc_out(g[5]));

  initial begin
    forever #4 clk = ~clk;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready, data and error are taken at the rising edge that closes the access;
  // one idle edge follows so callers see the registers already updated
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    chk("ready wait", 32'(k), 32'h0000_0001);
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    evt[i] <= 1'b1;
    @(posedge clk);
    evt[i] <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [31:0] exp;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rdc("gate reset", dsmg_pkg::GATE_OFF[i], 32'h0);
    rdc("wake reset", dsmg_pkg::WAKE_OFF, 32'h0);
    $display("test reset values done");
    // nothing runs behind the gates here, so gating is safe
    for (int i = 0; i < 6; i++) begin
      wr(dsmg_pkg::GATE_OFF[i], 32'hFFFF_FFFF);
      rdc("gate bits", dsmg_pkg::GATE_OFF[i], GM[i]);
      chk("gate out", g[i], GM[i]);
    end
    wr(dsmg_pkg::GATE_OFF[0] + 16'h4, 32'h0000_0001);
    rdc("alias clear", dsmg_pkg::GATE_OFF[0], 32'h0010_1100);
    wr(dsmg_pkg::GATE_OFF[0] + 16'h8, 32'h0000_0001);
    rdc("alias set", dsmg_pkg::GATE_OFF[0], 32'h0010_1101);
    wr(dsmg_pkg::GATE_OFF[0] + 16'hC, 32'h0010_0000);
    rdc("alias invert", dsmg_pkg::GATE_OFF[0], 32'h0000_1101);
    $display("test gates done");
    wr(dsmg_pkg::CONFIGURATION_CONTROL_OFF, 32'h0000_1000);
    chk("lock set", {31'h0, lock}, 32'h1);
    wr(dsmg_pkg::GATE_OFF[0], 32'h0000_0000);
    chk("locked write error", {31'h0, e}, 32'h0);
    rdc("locked gate", dsmg_pkg::GATE_OFF[0], 32'h0000_1101);
    unl <= 1'b0;
    wr(dsmg_pkg::CONFIGURATION_CONTROL_OFF, 32'h0000_0000);
    chk("lock without unlock", {31'h0, lock}, 32'h1);
    unl <= 1'b1;
    cfg3 <= 32'h1000_0000;
    wr(dsmg_pkg::CONFIGURATION_CONTROL_OFF, 32'h0000_0000);
    chk("lock one way", {31'h0, lock}, 32'h1);
    do_reset();
    chk("lock after reset", {31'h0, lock}, 32'h0);
    chk("gate after reset", g[0], 32'h0);
    cfg3 <= 32'h0000_0000;
    wr(dsmg_pkg::CONFIGURATION_CONTROL_OFF, 32'h0000_1000);
    wr(dsmg_pkg::CONFIGURATION_CONTROL_OFF, 32'h0000_0000);
    chk("lock cleared", {31'h0, lock}, 32'h0);
    apb(1'b0, 16'h1000, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test lock done");
    wr(dsmg_pkg::SCR_FIRST_OFF, 32'hA5A5_0001);
    wr(dsmg_pkg::SCR_FIRST_OFF + 16'h14, 32'h5A5A_0005);
    wr(dsmg_pkg::SCR_LAST_OFF, 32'hC3C3_0020);
    do_reset();
    rdc("word 5 reset", dsmg_pkg::SCR_FIRST_OFF + 16'h14, 32'h5A5A_0005);
    rdc("word 32 reset", dsmg_pkg::SCR_LAST_OFF, 32'hC3C3_0020);
    bat <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("word 0 battery", dsmg_pkg::SCR_FIRST_OFF, 32'hA5A5_0001);
    rdc("word 5 lost", dsmg_pkg::SCR_FIRST_OFF + 16'h14, 32'h0);
    rdc("word 32 lost", dsmg_pkg::SCR_LAST_OFF, 32'h0);
    bat <= 1'b0;
    wr(dsmg_pkg::DSCTL_OFF, 32'h0000_2000);
    wr(dsmg_pkg::DSCTL_OFF, 32'h0000_2000);
    chk("retention out", {31'h0, ret}, 32'h1);
    wr(dsmg_pkg::SCR_FIRST_OFF + 16'h14, 32'h5A5A_0055);
    dsa <= 1'b1;
    repeat (3) @(posedge clk);
    rdc("word 5 kept", dsmg_pkg::SCR_FIRST_OFF + 16'h14, 32'h5A5A_0055);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    rdc("word 5 sleep supply", dsmg_pkg::SCR_FIRST_OFF + 16'h14, 32'h5A5A_0055);
    dsa <= 1'b0;
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    rdc("word 0 supply reset", dsmg_pkg::SCR_FIRST_OFF, 32'h0);
    $display("test scratch done");
    pulse(0);
    rdc("event awake", dsmg_pkg::WAKE_OFF, 32'h0);
    dsa <= 1'b1;
    pulse(4);
    rdc("pin not enabled", dsmg_pkg::WAKE_OFF, 32'h0);
    mce <= 1'b1;
    exp = 32'h0;
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      exp[FB[i]] = 1'b1;
      rdc("wake flag", dsmg_pkg::WAKE_OFF, exp);
    end
    repeat (5) @(posedge clk);
    rdc("flags held", dsmg_pkg::WAKE_OFF, 32'h0000_019C);
    wr(dsmg_pkg::WAKE_OFF, 32'h0000_0100);
    rdc("flag write zero", dsmg_pkg::WAKE_OFF, 32'h0000_0100);
    wr(dsmg_pkg::DSCTL_OFF, 32'h0000_8000);
    wr(dsmg_pkg::DSCTL_OFF, 32'h0000_8000);
    chk("select out", {31'h0, dsel}, 32'h1);
    rdc("flags cleared", dsmg_pkg::WAKE_OFF, 32'h0);
    dsa <= 1'b0;
    repeat (2) @(posedge clk);
    chk("select on wake", {31'h0, dsel}, 32'h0);
    $display("test wake done");
    close_out();
  end

  // Generous bound: the sequence needs well under 5000 cycles
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule

// *** rtl/dsmg_if.sv ***
// Purpose: Link between the register front end and the persistent word store
// Assumes: Single clock domain
// Notes: Read data is combinational from the store

interface dsmg_if;
  logic wr_en;
  logic [5:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic retain_en;
  logic loss;
  logic por;

  modport ctrl (output wr_en, idx, wdata, retain_en, loss, por, input rdata);
  modport store (input wr_en, idx, wdata, retain_en, loss, por, output rdata);
endinterface

// *** rtl/dsmg_pkg.sv ***
// Purpose: Shared constants and types for the deep sleep wake and module gating block
// Assumes: APB slave with 32-bit data and a 16-bit byte address
// Notes: Addresses are byte addresses within the block's window

package dsmg_pkg;

  // ****************************************
  // Bus and address map
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] DSCTL_OFF = 16'h0000;
  localparam logic [15:0] WAKE_OFF = 16'h0010;
  localparam logic [15:0] SCR_FIRST_OFF = 16'h003C;
  localparam logic [15:0] SCR_LAST_OFF = 16'h00BC;
  localparam logic [15:0] CONFIGURATION_CONTROL_OFF = 16'hF200;
  localparam int GATE_REGS = 6;
  localparam logic [15:0] GATE_OFF [GATE_REGS] = '{
    16'hF240, 16'hF250, 16'hF260, 16'hF270, 16'hF280, 16'hF290
  };
  localparam logic [2:0] GATE_NONE = 3'h7;
  localparam int SCR_WORDS = 33;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DSEL_BIT = 15;
  localparam int RETAIN_BIT = 13;
  localparam int LOCK_BIT = 12;
  localparam int ONE_WAY_BIT = 28;
  localparam int CN_FLAG_BIT = 8;
  localparam int FAULT_FLAG_BIT = 7;
  localparam int WDT_FLAG_BIT = 4;
  localparam int ALARM_FLAG_BIT = 3;
  localparam int MASTER_CLEAR_PIN_FLAG_BIT = 2;
  localparam logic [31:0] WAKE_MASK = 32'h0000_019C;
  localparam logic [31:0] GATE_MASK [GATE_REGS] = '{
    32'h0010_1101, 32'h0000_0007, 32'h001F_001F,
    32'h0000_001F, 32'h0103_0303, 32'h0001_0003
  };

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] GATE_RST = 32'h0000_0000;
  localparam logic [31:0] WAKE_RST = 32'h0000_0000;
  localparam logic DSEL_RST = 1'b0;
  localparam logic RETAIN_RST = 1'b0;
  localparam logic LOCK_RST = 1'b0;

  // ****************************************
  // Alias operations, selected by address bits 3:2
  // ****************************************
  typedef enum logic [1:0] {
    DSMG_AL_WRITE = 2'b00,
    DSMG_AL_CLR = 2'b01,
    DSMG_AL_SET = 2'b10,
    DSMG_AL_INV = 2'b11
  } dsmg_alias_t;

endpackage

// *** rtl/dsmg_scratch.sv ***
// Purpose: Persistent scratch words that survive deep sleep and device resets
// Assumes: loss is a one-cycle pulse from the front end; por follows the supply reset input level outside deep sleep
// Notes: No device reset reaches the array on purpose

module dsmg_scratch #(
  parameter int WORDS = dsmg_pkg::SCR_WORDS
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  dsmg_if.store port_if
);

  logic [31:0] mem_reg [WORDS];
  logic [31:0] mem_next [WORDS];

  // ****************************************
  // Next state of the words
  // ****************************************
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      mem_next[i] = mem_reg[i];
      if (port_if.por) begin
        mem_next[i] = '0;
      end else if (port_if.loss && (i != 0) && !port_if.retain_en) begin
        mem_next[i] = '0;
      end
      if (port_if.wr_en && (port_if.idx == 6'(i))) begin
        mem_next[i] = port_if.wdata;
      end
    end
  end

  // Contents start undefined; device reset must not clear them
  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < WORDS; i++) begin
      mem_reg[i] <= mem_next[i];
    end
  end

  assign port_if.rdata = (port_if.idx < 6'(WORDS)) ? mem_reg[port_if.idx] : '0;

  // ****************************************
  // Checks
  // ****************************************
  a_word0_kept: assert property (@(posedge mclk_in) disable iff (reset_in)
    (port_if.loss && !port_if.por && !(port_if.wr_en && port_if.idx == 6'h00))
    |=> (mem_reg[0] == $past(mem_reg[0])))
    else $error("word zero changed on a retention loss");

  a_unretained_lost: assert property (@(posedge mclk_in) disable iff (reset_in)
    (port_if.loss && !port_if.retain_en && !port_if.wr_en) |=> (mem_reg[1] == 32'h0000_0000))
    else $error("word one kept without retention enable");

endmodule

// *** rtl/dsmg_top.sv ***
// Purpose: Wake-source flags, persistent words and peripheral clock gates behind APB
// Assumes: All inputs synchronous to mclk_in; zero-wait APB with registered answer
// Notes: Gate outputs stop clocks and block register writes of each peripheral
//
// The APB slave port was decided locally.

module dsmg_top (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic system_unlocked_in,
  input wire logic [31:0] configuration_word_three_in,
  input wire logic deep_sleep_active_in,
  input wire logic battery_mode_in,
  input wire logic supply_por_in,
  input wire logic change_notice_event_in,
  input wire logic sleep_fault_event_in,
  input wire logic sleep_watchdog_expiry_in,
  input wire logic calendar_alarm_in,
  input wire logic master_clear_enable_in,
  input wire logic master_clear_pin_in,
  output logic deep_sleep_select_out,
  output logic scratch_retention_enable_out,
  output logic gate_write_lock_out,
  output logic [31:0] module_gate_analog_out,
  output logic [31:0] module_gate_comparators_out,
  output logic [31:0] module_gate_capture_compare_out,
  output logic [31:0] module_gate_timers_out,
  output logic [31:0] module_gate_serial_out,
  output logic [31:0] module_gate_misc_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] gate_index(input logic [15:0] addr);
    logic [2:0] hit;
    hit = dsmg_pkg::GATE_NONE;
    for (int i = 0; i < dsmg_pkg::GATE_REGS; i++) begin
      if ((addr[15:4] == dsmg_pkg::GATE_OFF[i][15:4]) && (addr[1:0] == 2'b00)) begin
        hit = 3'(i);
      end
    end
    return hit;
  endfunction

  function automatic logic [31:0] alias_apply(input logic [31:0] old_val,
      input logic [31:0] wdata, input dsmg_pkg::dsmg_alias_t op, input logic [31:0] mask);
    logic [31:0] res;
    res = old_val;
    case (op)
      dsmg_pkg::DSMG_AL_WRITE: res = wdata;
      dsmg_pkg::DSMG_AL_CLR: res = old_val & ~wdata;
      dsmg_pkg::DSMG_AL_SET: res = old_val | wdata;
      dsmg_pkg::DSMG_AL_INV: res = old_val ^ wdata;
      default: res = old_val;
    endcase
    return res & mask;
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] wake_reg, wake_next;
  logic dsel_reg, dsel_next;
  logic retain_reg, retain_next;
  logic lock_reg, lock_next;
  logic lock_seen_reg, lock_seen_next;
  logic ds_prev_reg;
  logic lowpower_prev_reg;
  logic [31:0] gate_reg [dsmg_pkg::GATE_REGS];
  logic [31:0] gate_next [dsmg_pkg::GATE_REGS];

  dsmg_if scr_if ();

  // ****************************************
  // Address decode
  // ****************************************
  logic setup_phase;
  logic bus_write;
  logic [2:0] gate_sel;
  logic hit_dsctl;
  logic hit_wake;
  logic hit_cfg;
  logic hit_scr;
  logic mapped;
  logic ctl_write_ok;
  logic [31:0] wake_set;
  logic one_way;

  assign setup_phase = psel_in && !penable_in;
  // Writes take effect only at the access edge that sees pready high
  assign bus_write = psel_in && penable_in && pready_reg && pwrite_in;
  assign gate_sel = gate_index(paddr_in);
  assign hit_dsctl = (paddr_in == dsmg_pkg::DSCTL_OFF);
  assign hit_wake = (paddr_in == dsmg_pkg::WAKE_OFF);
  assign hit_cfg = (paddr_in == dsmg_pkg::CONFIGURATION_CONTROL_OFF);
  assign hit_scr = (paddr_in >= dsmg_pkg::SCR_FIRST_OFF) &&
                   (paddr_in <= dsmg_pkg::SCR_LAST_OFF) && (paddr_in[1:0] == 2'b00);
  assign mapped = hit_dsctl || hit_wake || hit_cfg || hit_scr ||
                  (gate_sel != dsmg_pkg::GATE_NONE);
  assign one_way = configuration_word_three_in[dsmg_pkg::ONE_WAY_BIT];
  // Control writes without the unlock sequence are dropped quietly
  assign ctl_write_ok = bus_write && hit_dsctl && system_unlocked_in;

  // ****************************************
  // Persistent word store
  // ****************************************
  logic [15:0] scr_byte;
  assign scr_byte = paddr_in - dsmg_pkg::SCR_FIRST_OFF;
  assign scr_if.idx = scr_byte[7:2];
  assign scr_if.wr_en = bus_write && hit_scr;
  assign scr_if.wdata = pwdata_in;
  assign scr_if.retain_en = retain_reg;
  assign scr_if.loss = (deep_sleep_active_in || battery_mode_in) && !lowpower_prev_reg;
  assign scr_if.por = supply_por_in && !deep_sleep_active_in;

  dsmg_scratch #(
    .WORDS(dsmg_pkg::SCR_WORDS)
  ) u_scratch (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .port_if(scr_if)
  );

  // ****************************************
  // Wake-source flags
  // ****************************************
  always_comb begin
    wake_set = '0;
    wake_set[dsmg_pkg::CN_FLAG_BIT] = change_notice_event_in && deep_sleep_active_in;
    wake_set[dsmg_pkg::FAULT_FLAG_BIT] = sleep_fault_event_in && deep_sleep_active_in;
    wake_set[dsmg_pkg::WDT_FLAG_BIT] = sleep_watchdog_expiry_in && deep_sleep_active_in;
    wake_set[dsmg_pkg::ALARM_FLAG_BIT] = calendar_alarm_in && deep_sleep_active_in;
    wake_set[dsmg_pkg::MASTER_CLEAR_PIN_FLAG_BIT] = master_clear_enable_in && master_clear_pin_in &&
                                        deep_sleep_active_in;
    wake_next = wake_reg;
    if (bus_write && hit_wake) begin
      wake_next = wake_reg & pwdata_in;
    end
    if (ctl_write_ok && pwdata_in[dsmg_pkg::DSEL_BIT]) begin
      wake_next = '0;
    end
    wake_next = (wake_next | wake_set) & dsmg_pkg::WAKE_MASK;
  end

  // ****************************************
  // Deep sleep control and lock
  // ****************************************
  always_comb begin
    dsel_next = dsel_reg;
    retain_next = retain_reg;
    // Hardware drops the select on wake; a software write in the same cycle wins
    if (ds_prev_reg && !deep_sleep_active_in) begin
      dsel_next = 1'b0;
    end
    if (ctl_write_ok) begin
      dsel_next = pwdata_in[dsmg_pkg::DSEL_BIT];
      retain_next = pwdata_in[dsmg_pkg::RETAIN_BIT];
    end
    lock_next = lock_reg;
    if (bus_write && hit_cfg && system_unlocked_in) begin
      if (pwdata_in[dsmg_pkg::LOCK_BIT]) begin
        lock_next = 1'b1;
      end else if (!(one_way && lock_seen_reg)) begin
        lock_next = 1'b0;
      end
    end
    lock_seen_next = lock_seen_reg || lock_next;
  end

  // ****************************************
  // Module gate registers
  // ****************************************
  always_comb begin
    for (int i = 0; i < dsmg_pkg::GATE_REGS; i++) begin
      gate_next[i] = gate_reg[i];
      if (bus_write && !lock_reg && (gate_sel == 3'(i))) begin
        gate_next[i] = alias_apply(gate_reg[i], pwdata_in,
                                   dsmg_pkg::dsmg_alias_t'(paddr_in[3:2]),
                                   dsmg_pkg::GATE_MASK[i]);
      end
    end
  end

  // ****************************************
  // APB answer, prepared in the setup cycle
  // ****************************************
  always_comb begin
    pready_next = setup_phase;
    pslverr_next = setup_phase && !mapped;
    prdata_next = '0;
    if (setup_phase && !pwrite_in) begin
      if (hit_dsctl) begin
        prdata_next[dsmg_pkg::DSEL_BIT] = dsel_reg;
        prdata_next[dsmg_pkg::RETAIN_BIT] = retain_reg;
      end else if (hit_wake) begin
        prdata_next = wake_reg & dsmg_pkg::WAKE_MASK;
      end else if (hit_cfg) begin
        prdata_next[dsmg_pkg::LOCK_BIT] = lock_reg;
      end else if (hit_scr) begin
        prdata_next = scr_if.rdata;
      end else if (gate_sel != dsmg_pkg::GATE_NONE) begin
        prdata_next = gate_reg[gate_sel];
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      wake_reg <= dsmg_pkg::WAKE_RST;
      dsel_reg <= dsmg_pkg::DSEL_RST;
      retain_reg <= dsmg_pkg::RETAIN_RST;
      lock_reg <= dsmg_pkg::LOCK_RST;
      lock_seen_reg <= 1'b0;
      ds_prev_reg <= 1'b0;
      lowpower_prev_reg <= 1'b0;
      for (int i = 0; i < dsmg_pkg::GATE_REGS; i++) begin
        gate_reg[i] <= dsmg_pkg::GATE_RST;
      end
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      wake_reg <= wake_next;
      dsel_reg <= dsel_next;
      retain_reg <= retain_next;
      lock_reg <= lock_next;
      lock_seen_reg <= lock_seen_next;
      ds_prev_reg <= deep_sleep_active_in;
      lowpower_prev_reg <= deep_sleep_active_in || battery_mode_in;
      for (int i = 0; i < dsmg_pkg::GATE_REGS; i++) begin
        gate_reg[i] <= gate_next[i];
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign deep_sleep_select_out = dsel_reg;
  assign scratch_retention_enable_out = retain_reg;
  assign gate_write_lock_out = lock_reg;
  assign module_gate_analog_out = gate_reg[0];
  assign module_gate_comparators_out = gate_reg[1];
  assign module_gate_capture_compare_out = gate_reg[2];
  assign module_gate_timers_out = gate_reg[3];
  assign module_gate_serial_out = gate_reg[4];
  assign module_gate_misc_out = gate_reg[5];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_cn_flag_set: assert property (
    (change_notice_event_in && deep_sleep_active_in) |=> wake_reg[dsmg_pkg::CN_FLAG_BIT])
    else $error("change-notice flag not set");

  a_fault_flag_set: assert property (
    (sleep_fault_event_in && deep_sleep_active_in) |=> wake_reg[dsmg_pkg::FAULT_FLAG_BIT])
    else $error("fault flag not set");

  a_wdt_flag_rise: assert property (
    $rose(wake_reg[dsmg_pkg::WDT_FLAG_BIT]) |->
    $past(sleep_watchdog_expiry_in && deep_sleep_active_in))
    else $error("watchdog flag rose without expiry in sleep");

  a_alarm_flag_set: assert property (
    (calendar_alarm_in && deep_sleep_active_in) |=> wake_reg[dsmg_pkg::ALARM_FLAG_BIT])
    else $error("alarm flag not set");

  a_master_clear_pin_flag_cause: assert property (
    $rose(wake_reg[dsmg_pkg::MASTER_CLEAR_PIN_FLAG_BIT]) |->
    $past(master_clear_enable_in && master_clear_pin_in && deep_sleep_active_in))
    else $error("master clear flag without enabled asserted pin");

  a_select_clears_flags: assert property (
    (ctl_write_ok && pwdata_in[dsmg_pkg::DSEL_BIT] && (wake_set == 32'h0000_0000))
    |=> (wake_reg == 32'h0000_0000))
    else $error("wake flags survived deep sleep select");

  a_wake_reserved_zero: assert property (
    (psel_in && penable_in && pready_out && hit_wake && !pwrite_in)
    |-> ((prdata_out & ~dsmg_pkg::WAKE_MASK) == 32'h0000_0000))
    else $error("reserved wake bits read nonzero");

  a_lock_discards: assert property (
    (bus_write && lock_reg && (gate_sel != dsmg_pkg::GATE_NONE))
    |=> ($stable(module_gate_analog_out) && $stable(module_gate_comparators_out) &&
         $stable(module_gate_capture_compare_out) && $stable(module_gate_timers_out) &&
         $stable(module_gate_serial_out) && $stable(module_gate_misc_out)))
    else $error("locked gate register changed");

  a_one_way_hold: assert property (
    (lock_reg && lock_seen_reg && one_way) |=> lock_reg)
    else $error("one-way lock was cleared");

  a_alias_set_bits: assert property (
    (bus_write && !lock_reg && (gate_sel == 3'h0) &&
     (paddr_in[3:2] == dsmg_pkg::DSMG_AL_SET))
    |=> ((module_gate_analog_out & $past(pwdata_in) & dsmg_pkg::GATE_MASK[0]) ==
         ($past(pwdata_in) & dsmg_pkg::GATE_MASK[0])))
    else $error("set alias did not set bits");

endmodule
